/* endec_regs.sv */
`include "endec_regs_map.svh"

module endec_regs
    import endec_regs_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // register port
    input wire logic [6:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // core status
    input wire logic CHIP_BUSY_I,
    input wire logic ECC_BUSY_I,
    input wire logic XFER_ACTIVE_I,
    input wire logic [7:0] CORR_COUNT_I,
    input wire logic IRQ_PENDING_I,
    // pins
    input wire logic [7:0] GPIN_I,
    input wire logic [1:0] EDGE_IRQ_I,
    output logic [7:0] GPOUT_O,
    output logic IRQ_O,
    output logic IRQ_OE_O,
    // control pulses
    output logic CHIP_RESET_O,
    output logic HALT_O,
    output logic ERR_RESET_O,
    output logic ECC_START_O,
    // configuration
    output logic [7:0] CFG1_O,
    output logic [7:0] CFG2_O,
    output logic [7:0] CFG3_O,
    output logic [7:0] SPT_O,
    output logic [7:0] TSEC_O,
    output logic [15:0] TTRK_O,
    output logic [7:0] CSEC_O,
    output logic [15:0] CTRK_O,
    output logic [7:0] XCNT_O,
    output logic [21:0] BUF_ADDR_O,
    output logic [7:0] IEN_O,
    output logic [7:0] MEN_O,
    output logic [7:0] TWIN_O,
    output logic [7:0] TEST_O
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic access_e acc_of(input addr_t a);
        if (a >= `OFS_CFG1 && a <= `OFS_XCNT) acc_of = ACC_RW;
        else if (a == `OFS_CCNT || a == `OFS_REV || a == `OFS_GPIN) acc_of = ACC_RO;
        else if (a >= `OFS_BAL && a <= `OFS_BAH) acc_of = ACC_RW;
        else if (a == `OFS_IEN || a == `OFS_MEN) acc_of = ACC_RW;
        else if (a >= `OFS_USR0 && a <= `OFS_GPOUT) acc_of = ACC_RW;
        else if (a == `OFS_TWIN) acc_of = ACC_WO;
        else if (a == `OFS_TEST) acc_of = ACC_RW;
        else if (a >= `OFS_BAL_A && a <= `OFS_BAH_A) acc_of = ACC_RW;
        else acc_of = ACC_NONE;
    endfunction

    // alias fold: alias offsets map onto the primary slot
    function automatic addr_t fold(input addr_t a);
        if (a >= `OFS_BAL_A && a <= `OFS_BAH_A) fold = 7'(a - `OFS_BAL_A + `OFS_BAL);
        else fold = a;
    endfunction

    addr_t wa;
    logic wen;
    assign wa = fold(ADDR_I);
    // writes to reserved or read-only offsets ignored
    assign wen = WR_I && (acc_of(ADDR_I) == ACC_RW || acc_of(ADDR_I) == ACC_WO)
        && ADDR_I != `OFS_GPIN;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] cfg1_q, cfg2_q, cfg3_q, spt_q, tsec_q, ttl_q, tth_q;
    logic [7:0] csec_q, ctl_q, cth_q, xcnt_q, bal_q, bam_q, bah_q;
    logic [7:0] ien_q, men_q, gpout_q, twin_q, test_q;
    logic [7:0] usr_q [4];

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cfg1_q <= `RST_BYTE;
        end else if (wen && wa == `OFS_CFG1) begin
            // mode and suppress bits stored, control bits as levels
            cfg1_q <= WDATA_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cfg2_q <= `RST_BYTE;
            cfg3_q <= `RST_BYTE;
            spt_q <= `RST_BYTE;
            tsec_q <= `RST_BYTE;
            ttl_q <= `RST_BYTE;
            tth_q <= `RST_BYTE;
            csec_q <= `RST_BYTE;
            ctl_q <= `RST_BYTE;
            cth_q <= `RST_BYTE;
            xcnt_q <= `RST_BYTE;
        end else if (wen) begin
            case (wa)
                // reserved bits 7 and 2 dropped
                `OFS_CFG2: cfg2_q <= WDATA_I & `CFG2_MASK;
                `OFS_CFG3: cfg3_q <= WDATA_I;
                `OFS_SPT: spt_q <= WDATA_I;
                `OFS_TSEC: tsec_q <= WDATA_I;
                `OFS_TTRL: ttl_q <= WDATA_I;
                `OFS_TTRH: tth_q <= WDATA_I;
                `OFS_CSEC: csec_q <= WDATA_I & `SEC_MASK;
                `OFS_CTRL: ctl_q <= WDATA_I;
                `OFS_CTRH: cth_q <= WDATA_I;
                `OFS_XCNT: xcnt_q <= WDATA_I;
                default: ;
            endcase
        end
    end

    // buffer address shared by primary and alias
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bal_q <= `RST_BYTE;
            bam_q <= `RST_BYTE;
            bah_q <= `RST_BYTE;
        end else if (wen) begin
            case (wa)
                `OFS_BAL: bal_q <= WDATA_I;
                `OFS_BAM: bam_q <= WDATA_I;
                `OFS_BAH: bah_q <= WDATA_I & `BAH_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ien_q <= `RST_BYTE;
            men_q <= `RST_BYTE;
        end else if (wen && wa == `OFS_IEN) begin
            ien_q <= WDATA_I;
        end else if (wen && wa == `OFS_MEN) begin
            men_q <= WDATA_I;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_usr
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    usr_q[gi] <= `RST_BYTE;
                end else if (wen && wa == 7'(`OFS_USR0 + gi)) begin
                    usr_q[gi] <= WDATA_I;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            gpout_q <= `RST_BYTE;
            twin_q <= `RST_BYTE;
            test_q <= `RST_BYTE;
        end else if (wen) begin
            case (wa)
                `OFS_GPOUT: gpout_q <= WDATA_I;
                `OFS_TWIN: twin_q <= WDATA_I;
                `OFS_TEST: test_q <= WDATA_I;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // command pulses
    // ------------------------------------------------------------
    logic rst_p_q, halt_p_q, erst_p_q, start_p_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rst_p_q <= 1'b0;
            halt_p_q <= 1'b0;
            erst_p_q <= 1'b0;
            start_p_q <= 1'b0;
        end else begin
            // chip reset, halt and error reset as one-cycle pulses
            rst_p_q <= wen && wa == `OFS_CFG1 && WDATA_I[`BIT_RESET];
            halt_p_q <= wen && wa == `OFS_CFG1 && WDATA_I[`BIT_HALT];
            erst_p_q <= wen && wa == `OFS_CFG1 && WDATA_I[`BIT_ERST];
            start_p_q <= wen && wa == `OFS_CFG1 && WDATA_I[`BIT_START];
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] rd_d;
    always_comb begin
        rd_d = 8'h00;
        case (fold(ADDR_I))
            // bits 6 and 4 read back busy
            `OFS_CFG1: rd_d = {cfg1_q[7], CHIP_BUSY_I, cfg1_q[5], ECC_BUSY_I, cfg1_q[3:0]};
            `OFS_CFG2: rd_d = cfg2_q;
            `OFS_CFG3: rd_d = cfg3_q;
            `OFS_SPT: rd_d = spt_q;
            `OFS_TSEC: rd_d = tsec_q;
            `OFS_TTRL: rd_d = ttl_q;
            `OFS_TTRH: rd_d = tth_q;
            `OFS_CSEC: rd_d = csec_q;
            `OFS_CTRL: rd_d = ctl_q;
            `OFS_CTRH: rd_d = cth_q;
            `OFS_XCNT: rd_d = xcnt_q;
            `OFS_CCNT: rd_d = CORR_COUNT_I;
            `OFS_BAL: rd_d = bal_q;
            `OFS_BAM: rd_d = bam_q;
            `OFS_BAH: rd_d = {XFER_ACTIVE_I, bah_q[6:0]};
            `OFS_REV: rd_d = `REV_VALUE;
            `OFS_IEN: rd_d = ien_q;
            `OFS_MEN: rd_d = men_q;
            `OFS_USR0: rd_d = usr_q[0];
            `OFS_USR1: rd_d = usr_q[1];
            `OFS_USR2: rd_d = usr_q[2];
            `OFS_USR3: rd_d = usr_q[3];
            `OFS_GPIN: rd_d = GPIN_I;
            // disabled edge inputs read like general inputs
            `OFS_EDGE: rd_d = {6'h00, edge_lvl_q};
            `OFS_GPOUT: rd_d = gpout_q;
            `OFS_TEST: rd_d = test_q;
            // write-only and reserved offsets read zero
            default: rd_d = 8'h00;
        endcase
    end

    logic [7:0] rdata_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) rdata_q <= 8'h00;
        else if (RD_I) rdata_q <= rd_d;
    end

    // edge inputs status readable when their enable is clear
    logic [1:0] edge_lvl_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) edge_lvl_q <= 2'b00;
        else edge_lvl_q <= EDGE_IRQ_I & ~{ien_q[`BIT_GP1_EN], ien_q[`BIT_GP0_EN]};
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RDATA_O = rdata_q;
    assign GPOUT_O = gpout_q;
    assign IRQ_O = cfg3_q[`BIT_IRQ_NEG] ? ~IRQ_PENDING_I : IRQ_PENDING_I;
    assign IRQ_OE_O = ~cfg3_q[`BIT_IRQ_OFF];
    assign CHIP_RESET_O = rst_p_q;
    assign HALT_O = halt_p_q;
    assign ERR_RESET_O = erst_p_q;
    assign ECC_START_O = start_p_q;
    assign CFG1_O = cfg1_q;
    assign CFG2_O = cfg2_q;
    assign CFG3_O = cfg3_q;
    assign SPT_O = spt_q;
    assign TSEC_O = tsec_q;
    assign TTRK_O = {tth_q, ttl_q};
    assign CSEC_O = csec_q;
    assign CTRK_O = {cth_q, ctl_q};
    assign XCNT_O = xcnt_q;
    assign BUF_ADDR_O = {bah_q[5:0], bam_q, bal_q};
    assign IEN_O = ien_q;
    assign MEN_O = men_q;
    assign TWIN_O = twin_q;
    assign TEST_O = test_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_alias_wr;
        WR_I && ADDR_I == `OFS_BAL_A;
    endsequence

    a_alias_low_write: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_alias_wr |=> bal_q == $past(WDATA_I))
        else $error("alias write missed low buffer byte");

    a_bah_reserved: assert property (@(posedge CLK_I) disable iff (RST_I)
        bah_q[7:6] == 2'b00)
        else $error("buffer high reserved bits stored");

    a_reset_pulse: assert property (@(posedge CLK_I) disable iff (RST_I)
        (WR_I && ADDR_I == `OFS_CFG1 && WDATA_I[7]) |=> CHIP_RESET_O)
        else $error("chip reset pulse wrong");

    a_reset_cause: assert property (@(posedge CLK_I) disable iff (RST_I)
        CHIP_RESET_O |-> $past(WR_I && ADDR_I == `OFS_CFG1 && WDATA_I[`BIT_RESET]))
        else $error("chip reset pulse without a write");

    a_halt_pulse: assert property (@(posedge CLK_I) disable iff (RST_I)
        (WR_I && ADDR_I == `OFS_CFG1 && WDATA_I[`BIT_HALT]) |=> HALT_O)
        else $error("halt pulse missing");

    a_start_pulse: assert property (@(posedge CLK_I) disable iff (RST_I)
        (WR_I && ADDR_I == `OFS_CFG1 && WDATA_I[4]) |=> ECC_START_O)
        else $error("corrector start missing");

    a_cfg2_reserved: assert property (@(posedge CLK_I) disable iff (RST_I)
        (cfg2_q & ~`CFG2_MASK) == 8'h00)
        else $error("config two reserved bits set");

    a_irq_polarity: assert property (@(posedge CLK_I) disable iff (RST_I)
        IRQ_O == (IRQ_PENDING_I ^ cfg3_q[6]) && IRQ_OE_O == !cfg3_q[7])
        else $error("interrupt pin wrong");

    a_track_join: assert property (@(posedge CLK_I) disable iff (RST_I)
        (WR_I && ADDR_I == `OFS_TTRH) |=> TTRK_O[15:8] == $past(WDATA_I))
        else $error("target track high byte lost");

    a_user_keep: assert property (@(posedge CLK_I) disable iff (RST_I)
        (WR_I && ADDR_I == `OFS_USR0) |=> usr_q[0] == $past(WDATA_I))
        else $error("user byte not stored");

    a_gpout_drive: assert property (@(posedge CLK_I) disable iff (RST_I)
        (WR_I && ADDR_I == `OFS_GPOUT) |=> GPOUT_O == $past(WDATA_I))
        else $error("output byte not driven");

    a_csec_reserved: assert property (@(posedge CLK_I) disable iff (RST_I)
        CSEC_O[7:6] == 2'b00)
        else $error("compare sector reserved bits stored");

    a_hidden_reads_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
        (RD_I && ADDR_I != `OFS_EDGE
            && (acc_of(ADDR_I) == ACC_NONE || acc_of(ADDR_I) == ACC_WO))
        |=> RDATA_O == 8'h00)
        else $error("hidden offset read nonzero");

    a_edge_view: assert property (@(posedge CLK_I) disable iff (RST_I)
        (RD_I && ADDR_I == `OFS_EDGE && !$past(RST_I)) |=> RDATA_O == {6'h00,
        $past(EDGE_IRQ_I, 2) & ~$past({IEN_O[`BIT_GP1_EN], IEN_O[`BIT_GP0_EN]}, 2)})
        else $error("edge input view wrong");

endmodule

/* endec_regs_map.svh */
// Overview of operation
// - buffer address low, mid and high bytes decode at primary and alias offsets
// - buffer address high: bits 5-0 address, bit 6 reserved, bit 7 transfer active
// - config one: bit 7 chip reset, bit 6 halt/busy, bit 5 error reset
// - config one: bit 4 start corrector/busy, bit 3 suppress vectors, bits 2-0 mode
// - config two: bit 6 segmentation, bit 5 pointer bytes enable, bit 4 source mode
// - config two: bit 3 speed tolerance, bit 1 disk size, bit 0 sector size
// - config three: bit 7 disables irq driver, bit 6 makes irq active low
// - config three bits 5-2: calibration window, gates, correction off, erasure pointers
// - config three: bit 1 forces encoded output high on erase, bit 0 continuous read
// - sector count in bits 5-0, edge input polarities in bits 7-6
// - target sector in bits 5-0, id copy selector in bits 7-6
// - target track is sixteen bits in low and high bytes
// - compare sector bits 5-0, reserved 7-6; compare track low and high
// - irq enable bits 7-4 mask media, correction, edge one, edge zero
// - irq enable bits 3-0: companion pass-through, compare found, count zero, done
// - media enable bits 7-5: pseudo mark access, mark outside window, id error
// - media enable bits 4-0: sync recovered, sync fatal, resync, written flag, done
// - four read-write user bytes keep the last value written
// - write-only test register sets the sector mark window
// - read-write test register for testing only
// - disabled edge inputs are readable like ordinary general inputs
`ifndef ENDEC_REGS_MAP_SVH
`define ENDEC_REGS_MAP_SVH
`define OFS_CFG1 7'h10
`define OFS_CFG2 7'h11
`define OFS_CFG3 7'h12
`define OFS_SPT 7'h13
`define OFS_TSEC 7'h14
`define OFS_TTRL 7'h15
`define OFS_TTRH 7'h16
`define OFS_CSEC 7'h17
`define OFS_CTRL 7'h18
`define OFS_CTRH 7'h19
`define OFS_XCNT 7'h1a
`define OFS_CCNT 7'h1b
`define OFS_BAL 7'h1c
`define OFS_BAM 7'h1d
`define OFS_BAH 7'h1e
`define OFS_REV 7'h1f
`define OFS_IEN 7'h20
`define OFS_MEN 7'h21
`define OFS_USR0 7'h34
`define OFS_USR1 7'h35
`define OFS_USR2 7'h36
`define OFS_USR3 7'h37
`define OFS_GPIN 7'h38
`define OFS_GPOUT 7'h39
`define OFS_TWIN 7'h3e
`define OFS_TEST 7'h3f
`define OFS_EDGE 7'h40
`define OFS_BAL_A 7'h57
`define OFS_BAM_A 7'h58
`define OFS_BAH_A 7'h59
`define CFG2_MASK 8'h7b
`define SEC_MASK 8'h3f
`define BAH_MASK 8'h3f
`define BIT_RESET 7
`define BIT_HALT 6
`define BIT_ERST 5
`define BIT_START 4
`define BIT_IRQ_OFF 7
`define BIT_IRQ_NEG 6
`define BIT_GP1_EN 5
`define BIT_GP0_EN 4
`define BIT_XFER 7
`define RST_BYTE 8'h00
// revision byte value is arbitrary
`define REV_VALUE 8'h01
`endif

/* endec_regs_pkg.sv */
package endec_regs_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] addr_t;
    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_RW,
        ACC_RO,
        ACC_WO
    } access_e;
endpackage

/* mcu_model.sv */
module mcu_model
    import endec_regs_pkg::*;
(
    // clock
    input wire logic clk_i,
    // register port
    output addr_t addr_o,
    output byte_t wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr_o = 7'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // ----------------------------------------
    // bus cycles, launched on the falling edge
    // ----------------------------------------
    // released lines show the inverse so stale values are never trusted
    task automatic write_reg(input addr_t a, input byte_t d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic read_reg(input addr_t a, output byte_t d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        d = rdata_i;
        rd_o = 1'b0;
        addr_o = ~a;
    endtask
endmodule

/* endec_regs_bench.sv */
module endec_regs_bench
    import endec_regs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, wr, rd, busy, ecc, xfer, pend, oe, irq;
    logic reset_p, halt_p, erst_p, start_p;
    addr_t addr;
    byte_t wdata, rdata, corr, gpin, gpout, cfg1, cfg3, twin;
    byte_t cfg2, spt, tsec, csec, xcnt, ien, men, testo;
    logic [1:0] edge_in;
    logic [15:0] ttrk, ctrk;
    logic [21:0] bufa;
    int err_count = 0;
    int samples_checked = 0;
    addr_t ofs[18] = '{7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19,
                       7'h1a, 7'h20, 7'h21, 7'h34, 7'h35, 7'h36, 7'h37, 7'h39, 7'h3f};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    mcu_model u_mcu_model (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .rdata_i(rdata));

    endec_regs u_endec_regs (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CHIP_BUSY_I(busy), .ECC_BUSY_I(ecc),
        .XFER_ACTIVE_I(xfer), .CORR_COUNT_I(corr), .IRQ_PENDING_I(pend), .GPIN_I(gpin),
        .EDGE_IRQ_I(edge_in), .GPOUT_O(gpout), .IRQ_O(irq), .IRQ_OE_O(oe),
        .CHIP_RESET_O(reset_p), .HALT_O(halt_p), .ERR_RESET_O(erst_p),
        .ECC_START_O(start_p), .CFG1_O(cfg1), .CFG2_O(cfg2), .CFG3_O(cfg3), .SPT_O(spt),
        .TSEC_O(tsec), .TTRK_O(ttrk), .CSEC_O(csec), .CTRK_O(ctrk), .XCNT_O(xcnt),
        .BUF_ADDR_O(bufa), .IEN_O(ien), .MEN_O(men), .TWIN_O(twin), .TEST_O(testo));

    // ----------------------------------------
    // checking and verdict
    // ----------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rchk(input addr_t a, input byte_t exp);
        byte_t d;
        u_mcu_model.read_reg(a, d);
        check($sformatf("offset %h", a), {16'h0000, d}, {16'h0000, exp});
    endtask

    task automatic print_verdict;
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        print_verdict();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        byte_t v, m;
        rst = 1'b1;
        busy = 1'b0;
        ecc = 1'b0;
        xfer = 1'b0;
        pend = 1'b0;
        corr = 8'h6c;
        gpin = 8'hc3;
        edge_in = 2'b01;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // pass 0 reset values, pass 1 all ones, pass 2 distinct pattern
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 18; i++) begin
                v = (p == 1) ? 8'hff : {ofs[i][3:0], ~ofs[i][3:0]};
                if (p > 0) u_mcu_model.write_reg(ofs[i], v);
            end
            for (int i = 0; i < 18; i++) begin
                v = (p == 1) ? 8'hff : {ofs[i][3:0], ~ofs[i][3:0]};
                m = (ofs[i] == 7'h11) ? 8'h7b : (ofs[i] == 7'h17) ? 8'h3f : 8'hff;
                rchk(ofs[i], (p == 0) ? 8'h00 : (v & m));
            end
        end
        check("target track", ttrk, 16'h695a);
        check("compare track", ctrk, 16'h9687);
        check("pin output", gpout, 8'h96);
        check("config three", cfg3, 8'h2d);
        check("config outputs", {cfg2, spt, tsec}, 24'h1a3c4b);
        check("compare outputs", {csec, xcnt, ien}, 24'h38a50f);
        check("media and test", {men, testo}, 16'h1ef0);
        // edge inputs read as plain inputs while their enables are clear
        edge_in = 2'b11;
        rchk(7'h40, 8'h03);
        u_mcu_model.write_reg(7'h20, 8'h10);
        rchk(7'h40, 8'h02);
        // interrupt polarity and driver enable
        pend = 1'b1;
        u_mcu_model.write_reg(7'h12, 8'h40);
        check("irq low active", {oe, irq}, 2'b10);
        pend = 1'b0;
        @(negedge clk);
        check("irq low idle", {oe, irq}, 2'b11);
        u_mcu_model.write_reg(7'h12, 8'h80);
        check("irq driver off", oe, 1'b0);
        // buffer address through both offsets
        u_mcu_model.write_reg(7'h57, 8'h11);
        u_mcu_model.write_reg(7'h58, 8'h22);
        u_mcu_model.write_reg(7'h59, 8'hff);
        rchk(7'h1c, 8'h11);
        rchk(7'h1d, 8'h22);
        rchk(7'h1e, 8'h3f);
        check("buffer address", bufa, 22'h3f2211);
        xfer = 1'b1;
        rchk(7'h59, 8'hbf);
        u_mcu_model.write_reg(7'h1c, 8'h33);
        rchk(7'h57, 8'h33);
        // read-only, write-only and reserved places
        u_mcu_model.write_reg(7'h1b, 8'h00);
        rchk(7'h1b, 8'h6c);
        u_mcu_model.write_reg(7'h38, 8'h00);
        rchk(7'h38, 8'hc3);
        u_mcu_model.write_reg(7'h3e, 8'h5e);
        check("mark window", twin, 8'h5e);
        rchk(7'h3e, 8'h00);
        u_mcu_model.write_reg(7'h3a, 8'h77);
        rchk(7'h3a, 8'h00);
        rchk(7'h2f, 8'h00);
        // config one control pulses, one bit at a time
        for (int b = 4; b < 8; b++) begin
            u_mcu_model.write_reg(7'h10, (8'h01 << b) | 8'h05);
            check("pulses", {reset_p, halt_p, erst_p, start_p}, 4'h1 << (b - 4));
            @(negedge clk);
            check("pulses end", {reset_p, halt_p, erst_p, start_p}, 4'h0);
        end
        check("config one", cfg1, 8'h85);
        busy = 1'b1;
        ecc = 1'b1;
        rchk(7'h10, 8'hd5);
        busy = 1'b0;
        ecc = 1'b0;
        rchk(7'h10, 8'h85);
        // a second reset clears the bank again
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rchk(7'h59, 8'h80);
        check("reset state", {cfg1, gpout, twin}, 24'h000000);
        check("reset irq driver", oe, 1'b1);
        print_verdict();
    end
endmodule
